// File: verilog/lnkcfg_pkg.sv
// package: register map, reset values and field positions of the link configuration block
package lnkcfg_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] LNKCFG_GEN_CFG1_OFS  = 8'h03;
    localparam logic [7:0] LNKCFG_EQ_CTRL_OFS   = 8'h04;
    localparam logic [7:0] LNKCFG_REMOTE_SERIALIZER_ADDRESS_OFS    = 8'h06;
    localparam logic [7:0] LNKCFG_SERIALIZER_ALIAS_ADDRESS_OFS = 8'h07;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] LNKCFG_GEN_CFG1_RST  = 8'hE9;
    localparam logic [7:0] LNKCFG_EQ_CTRL_RST   = 8'h00;
    localparam logic [7:0] LNKCFG_REMOTE_SERIALIZER_ADDRESS_RST    = 8'h00;
    localparam logic [7:0] LNKCFG_SERIALIZER_ALIAS_ADDRESS_RST = 8'h00;

    // ****************************************
    // general configuration 1 fields
    // ****************************************
    localparam int LNKCFG_PARITY_CHK_BIT = 7;
    localparam int LNKCFG_BC_CRC_BIT     = 6;
    localparam int LNKCFG_IO_AUTO_BIT    = 5;
    localparam int LNKCFG_IO_MODE_BIT    = 4;
    localparam int LNKCFG_PASS_BIT       = 3;
    localparam int LNKCFG_AUTO_ACK_BIT   = 2;
    localparam int LNKCFG_PAR_RST_BIT    = 1;
    localparam int LNKCFG_STROBE_BIT     = 0;

    // equalizer level field, bits 7:4
    localparam int LNKCFG_EQ_LVL_MSB = 7;
    localparam int LNKCFG_EQ_LVL_LSB = 4;

    // i2c byte framing
    localparam logic [3:0] LNKCFG_BYTE_BITS = 4'h8;

    // local i2c target address; value is arbitrary
    localparam logic [6:0] LNKCFG_DEV_ADDR_DFLT = 7'h3A;

    typedef enum logic [2:0] {
        LNKCFG_IDLE, LNKCFG_ADDR, LNKCFG_SUB, LNKCFG_WR, LNKCFG_ACK, LNKCFG_RD, LNKCFG_RACK
    } lnkcfg_state_type;
endpackage

// File: verilog/lnkcfg_regs.sv
// module: configuration registers behind the local i2c port, with pass-through to the remote serializer
// What this block does
// RULE1: bit6 enables back-channel crc generation, reset 1
// RULE2: bit5 selects auto io supply detection, reset 1
// RULE3: bit3 enables pass-through of alias-matched writes
// RULE4: auto acknowledge acks remote writes immediately
// RULE5: early-acked alias writes go to remote serializer address
// RULE6: bit1 holds parity logic reset, never self-clears
// RULE7: bit0 picks rising or falling strobe edge
// RULE8: equalizer bits 7:4 give bypass level, reset 0
// RULE9: serializer alias remapped to remote serializer address
// RULE10: equalizer reserved bits store writes, no effect
module lnkcfg_regs
    import lnkcfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = lnkcfg_pkg::LNKCFG_DEV_ADDR_DFLT
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    input  wire logic       i_pass_all,
    input  wire logic       i_remote_ack,
    output logic            o_fwd_start,
    output logic            o_fwd_valid,
    output logic [6:0]      o_fwd_addr,
    output logic [7:0]      o_fwd_data,
    output logic            o_parity_chk_en,
    output logic            o_bc_crc_en,
    output logic            o_io_auto_detect,
    output logic            o_io_mode_high,
    output logic            o_pass_through_en,
    output logic            o_auto_ack_en,
    output logic            o_parity_rst,
    output logic            o_strobe_rising,
    output logic [3:0]      o_eq_level
);
    import lnkcfg_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************
    // bus line edge detection
    // ****************************************
    logic scl_q, scl_p_q, sda_q, sda_p_q;
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_q   <= 1'b1;
            scl_p_q <= 1'b1;
            sda_q   <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_q   <= i_scl;
            scl_p_q <= scl_q;
            sda_q   <= i_sda;
            sda_p_q <= sda_q;
        end
    end

    wire scl_rise = scl_q & ~scl_p_q;
    wire scl_fall = ~scl_q & scl_p_q;
    wire bus_start = scl_q & scl_p_q & sda_p_q & ~sda_q;
    wire bus_stop  = scl_q & scl_p_q & ~sda_p_q & sda_q;

    // ****************************************
    // registers and decode
    // ****************************************
    logic [7:0] gen_cfg1_q, eq_ctrl_q, remote_serializer_address_q, serializer_alias_address_q;
    logic [7:0] ptr_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic       fwd_q;
    logic       ack_q;
    lnkcfg_state_type state_q, nxt_q;

    function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] g1, input logic [7:0] eq,
                                            input logic [7:0] sid, input logic [7:0] sal);
        unique case (ofs)
            LNKCFG_GEN_CFG1_OFS:  reg_read = g1;
            LNKCFG_EQ_CTRL_OFS:   reg_read = eq;
            LNKCFG_REMOTE_SERIALIZER_ADDRESS_OFS:    reg_read = sid;
            LNKCFG_SERIALIZER_ALIAS_ADDRESS_OFS: reg_read = sal;
            default:              reg_read = 8'h00;
        endcase
    endfunction

    wire [6:0] rx_addr    = shift_q[7:1];
    wire       rx_rd      = shift_q[0];
    wire       byte_done  = scl_fall & (cnt_q == LNKCFG_BYTE_BITS);
    wire       local_hit  = (rx_addr == DEV_ADDR);
    wire       pass_en    = gen_cfg1_q[LNKCFG_PASS_BIT];                                   // see RULE3
    wire       auto_ack   = gen_cfg1_q[LNKCFG_AUTO_ACK_BIT];
    wire       alias_hit  = pass_en & (serializer_alias_address_q[7:1] != 7'h00) & (rx_addr == serializer_alias_address_q[7:1])
                            & (remote_serializer_address_q[7:1] != 7'h00);                                     // see RULE3
    // writes to any other target only pass when forward-all is on, and then only with auto ack
    wire       any_hit    = pass_en & auto_ack & i_pass_all & ~local_hit;                  // see RULE4
    wire       remote_ok  = auto_ack | i_remote_ack;                                       // see RULE4
    wire [7:0] rd_data    = reg_read(ptr_q, gen_cfg1_q, eq_ctrl_q, remote_serializer_address_q, serializer_alias_address_q);
    wire       wr_local   = (state_q == LNKCFG_WR) & byte_done & ~fwd_q;

    // ****************************************
    // register file
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gen_cfg1_q  <= LNKCFG_GEN_CFG1_RST;
            eq_ctrl_q   <= LNKCFG_EQ_CTRL_RST;
            remote_serializer_address_q    <= LNKCFG_REMOTE_SERIALIZER_ADDRESS_RST;
            serializer_alias_address_q <= LNKCFG_SERIALIZER_ALIAS_ADDRESS_RST;
        end else if (wr_local) begin
            // no hardware path writes bit1, so parity reset holds until software clears it
            if (ptr_q == LNKCFG_GEN_CFG1_OFS)  gen_cfg1_q  <= shift_q;                    // see RULE6
            if (ptr_q == LNKCFG_EQ_CTRL_OFS)   eq_ctrl_q   <= shift_q;                    // see RULE10
            if (ptr_q == LNKCFG_REMOTE_SERIALIZER_ADDRESS_OFS)    remote_serializer_address_q    <= shift_q;
            if (ptr_q == LNKCFG_SERIALIZER_ALIAS_ADDRESS_OFS) serializer_alias_address_q <= shift_q;
        end
    end

    // ****************************************
    // i2c target engine
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q     <= LNKCFG_IDLE;
            nxt_q       <= LNKCFG_IDLE;
            cnt_q       <= 4'h0;
            shift_q     <= 8'h00;
            ptr_q       <= 8'h00;
            fwd_q       <= 1'b0;
            ack_q       <= 1'b0;
            o_sda_oe    <= 1'b0;
            o_fwd_start <= 1'b0;
            o_fwd_valid <= 1'b0;
            o_fwd_addr  <= 7'h00;
            o_fwd_data  <= 8'h00;
        end else begin
            o_fwd_start <= 1'b0;
            o_fwd_valid <= 1'b0;
            if (bus_stop) begin
                state_q  <= LNKCFG_IDLE;
                o_sda_oe <= 1'b0;
            end else if (bus_start) begin
                state_q  <= LNKCFG_ADDR;
                cnt_q    <= 4'h0;
                fwd_q    <= 1'b0;
                o_sda_oe <= 1'b0;
            end else begin
                unique case (state_q)
                    LNKCFG_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    LNKCFG_ADDR, LNKCFG_SUB, LNKCFG_WR: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_q};
                            cnt_q   <= cnt_q + 4'h1;
                        end else if (byte_done) begin
                            cnt_q   <= 4'h0;
                            state_q <= LNKCFG_ACK;
                            if (state_q == LNKCFG_ADDR) begin
                                if (local_hit) begin
                                    o_sda_oe <= 1'b1;
                                    nxt_q    <= rx_rd ? LNKCFG_RD : LNKCFG_SUB;
                                end else if ((alias_hit | any_hit) && !rx_rd && remote_ok) begin
                                    // serializer alias becomes the remote serializer address
                                    o_sda_oe    <= 1'b1;                                   // see RULE4
                                    fwd_q       <= 1'b1;
                                    o_fwd_start <= 1'b1;
                                    o_fwd_addr  <= alias_hit ? remote_serializer_address_q[7:1] : rx_addr;    // see RULE9
                                    nxt_q       <= LNKCFG_WR;
                                end else begin
                                    o_sda_oe <= 1'b0;
                                    nxt_q    <= LNKCFG_IDLE;
                                end
                            end else if (state_q == LNKCFG_SUB) begin
                                ptr_q    <= shift_q;
                                o_sda_oe <= 1'b1;
                                nxt_q    <= LNKCFG_WR;
                            end else if (fwd_q) begin
                                o_sda_oe    <= remote_ok;                                  // see RULE4
                                o_fwd_valid <= remote_ok;                                  // see RULE5
                                o_fwd_data  <= shift_q;
                                nxt_q       <= remote_ok ? LNKCFG_WR : LNKCFG_IDLE;
                            end else begin
                                ptr_q    <= ptr_q + 8'h01;
                                o_sda_oe <= 1'b1;
                                nxt_q    <= LNKCFG_WR;
                            end
                        end
                    end
                    LNKCFG_ACK: begin
                        if (scl_fall) begin
                            state_q <= nxt_q;
                            if (nxt_q == LNKCFG_RD) begin
                                shift_q  <= {rd_data[6:0], 1'b0};
                                o_sda_oe <= ~rd_data[7];
                                ptr_q    <= ptr_q + 8'h01;
                                cnt_q    <= 4'h1;
                            end else begin
                                o_sda_oe <= 1'b0;
                            end
                        end
                    end
                    LNKCFG_RD: begin
                        if (scl_fall) begin
                            if (cnt_q == LNKCFG_BYTE_BITS) begin
                                o_sda_oe <= 1'b0;
                                state_q  <= LNKCFG_RACK;
                            end else begin
                                o_sda_oe <= ~shift_q[7];
                                shift_q  <= {shift_q[6:0], 1'b0};
                                cnt_q    <= cnt_q + 4'h1;
                            end
                        end
                    end
                    LNKCFG_RACK: begin
                        if (scl_rise) begin
                            ack_q <= ~sda_q;
                        end else if (scl_fall) begin
                            state_q <= LNKCFG_IDLE;
                            if (ack_q) begin
                                state_q  <= LNKCFG_RD;
                                shift_q  <= {rd_data[6:0], 1'b0};
                                o_sda_oe <= ~rd_data[7];
                                ptr_q    <= ptr_q + 8'h01;
                                cnt_q    <= 4'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // configuration outputs
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_sda             <= 1'b0;
            o_parity_chk_en   <= LNKCFG_GEN_CFG1_RST[LNKCFG_PARITY_CHK_BIT];
            o_bc_crc_en       <= LNKCFG_GEN_CFG1_RST[LNKCFG_BC_CRC_BIT];
            o_io_auto_detect  <= LNKCFG_GEN_CFG1_RST[LNKCFG_IO_AUTO_BIT];
            o_io_mode_high    <= LNKCFG_GEN_CFG1_RST[LNKCFG_IO_MODE_BIT];
            o_pass_through_en <= LNKCFG_GEN_CFG1_RST[LNKCFG_PASS_BIT];
            o_auto_ack_en     <= LNKCFG_GEN_CFG1_RST[LNKCFG_AUTO_ACK_BIT];
            o_parity_rst      <= LNKCFG_GEN_CFG1_RST[LNKCFG_PAR_RST_BIT];
            o_strobe_rising   <= LNKCFG_GEN_CFG1_RST[LNKCFG_STROBE_BIT];
            o_eq_level        <= LNKCFG_EQ_CTRL_RST[LNKCFG_EQ_LVL_MSB:LNKCFG_EQ_LVL_LSB];
        end else begin
            o_sda             <= 1'b0;
            o_parity_chk_en   <= gen_cfg1_q[LNKCFG_PARITY_CHK_BIT];
            o_bc_crc_en       <= gen_cfg1_q[LNKCFG_BC_CRC_BIT];                           // see RULE1
            o_io_auto_detect  <= gen_cfg1_q[LNKCFG_IO_AUTO_BIT];                          // see RULE2
            o_io_mode_high    <= gen_cfg1_q[LNKCFG_IO_MODE_BIT];
            o_pass_through_en <= gen_cfg1_q[LNKCFG_PASS_BIT];                             // see RULE3
            o_auto_ack_en     <= gen_cfg1_q[LNKCFG_AUTO_ACK_BIT];                         // see RULE4
            o_parity_rst      <= gen_cfg1_q[LNKCFG_PAR_RST_BIT];                          // see RULE6
            o_strobe_rising   <= gen_cfg1_q[LNKCFG_STROBE_BIT];                           // see RULE7
            o_eq_level        <= eq_ctrl_q[LNKCFG_EQ_LVL_MSB:LNKCFG_EQ_LVL_LSB];          // see RULE8
        end
    end
endmodule // lnkcfg_regs

// File: dv/lnkcfg_regs_props.sv
// checker: port-level properties of the link configuration registers
module lnkcfg_regs_props (
    input wire logic       i_sys_clk,
    input wire logic       i_rstn,
    input wire logic       o_sda_oe,
    input wire logic       o_fwd_start,
    input wire logic       o_fwd_valid,
    input wire logic [6:0] o_fwd_addr,
    input wire logic       o_bc_crc_en,
    input wire logic       o_io_auto_detect,
    input wire logic       o_pass_through_en,
    input wire logic       o_auto_ack_en,
    input wire logic       o_parity_rst,
    input wire logic       o_strobe_rising,
    input wire logic [3:0] o_eq_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // ****
    // config moves only the cycle after a write lands, which is while ack drives
    // ****
    chk_cfg_by_write: assert property (
        $changed({o_bc_crc_en, o_io_auto_detect, o_strobe_rising}) |-> $past(o_sda_oe))
        else $error("config bit changed outside a register write");
    chk_parity_sticky: assert property ($fell(o_parity_rst) |-> $past(o_sda_oe))
        else $error("parity reset cleared without a write");
    chk_eq_by_write: assert property ($changed(o_eq_level) |-> $past(o_sda_oe))
        else $error("equalizer level changed outside a write");
    chk_fwd_needs_pass: assert property (o_fwd_start |-> o_pass_through_en)
        else $error("forward started with pass-through off");
    chk_fwd_at_ack: assert property (o_fwd_start && o_auto_ack_en |-> ##[0:3] o_sda_oe)
        else $error("forward start without early ack");
    chk_auto_ack_early: assert property (o_fwd_valid && o_auto_ack_en |-> ##[0:3] o_sda_oe)
        else $error("forwarded byte not acked at once");
    chk_fwd_addr_hold: assert property (o_fwd_valid |-> $stable(o_fwd_addr))
        else $error("forward address moved during a transfer");
    chk_fwd_pulse: assert property (o_fwd_valid |=> !o_fwd_valid && !o_fwd_start)
        else $error("forward strobe longer than one cycle");
    cover property (o_fwd_start);
    cover property (o_fwd_valid && o_auto_ack_en);
    cover property ($fell(o_parity_rst));
endmodule // lnkcfg_regs_props

bind lnkcfg_regs lnkcfg_regs_props u_lnkcfg_regs_props (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .o_sda_oe(o_sda_oe), .o_fwd_start(o_fwd_start),
    .o_fwd_valid(o_fwd_valid), .o_fwd_addr(o_fwd_addr), .o_bc_crc_en(o_bc_crc_en),
    .o_io_auto_detect(o_io_auto_detect), .o_pass_through_en(o_pass_through_en),
    .o_auto_ack_en(o_auto_ack_en), .o_parity_rst(o_parity_rst), .o_strobe_rising(o_strobe_rising),
    .o_eq_level(o_eq_level));

// File: dv/lnkcfg_remote_model.sv
// remote serializer stand-in: answers forwarded bytes and logs what arrived
module lnkcfg_remote_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_ack_en,
    input  wire logic       i_fwd_start,
    input  wire logic       i_fwd_valid,
    input  wire logic [6:0] i_fwd_addr,
    input  wire logic [7:0] i_fwd_data,
    output logic            o_remote_ack,
    output logic [6:0]      o_last_addr,
    output logic [7:0]      o_last_data,
    output logic [7:0]      o_byte_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // answer and log
    // ****
    // a refusing serializer shows no ack at all, as with the link down
    assign o_remote_ack = i_ack_en;
    initial begin
        o_last_addr = 7'h00;
        o_last_data = 8'h00;
        o_byte_cnt = 8'h00;
    end
    always @(posedge i_sys_clk) begin
        if (i_fwd_start) begin
            o_last_addr <= i_fwd_addr;
        end
        if (i_fwd_valid) begin
            o_last_data <= i_fwd_data;
            o_byte_cnt <= o_byte_cnt + 8'h01;
        end
    end
endmodule // lnkcfg_remote_model

// File: dv/tb_top.sv
// testbench: i2c-driven checks of the link configuration registers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lnkcfg_pkg::*;
    logic       sys_clk, rst_n, scl, m_sda, pass_all, ack_en, sda_oe, sda_o, fwd_start, fwd_valid, r_ack;
    logic [6:0] fwd_addr, last_addr;
    logic [7:0] fwd_data, last_data, byte_cnt;
    wire  [7:0] cfg;
    logic [3:0] eq;
    wire        sda_w = m_sda & ~(sda_oe & ~sda_o);
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    lnkcfg_regs u_lnkcfg_regs (.i_sys_clk(sys_clk), .i_rstn(rst_n), .i_scl(scl), .i_sda(sda_w),
        .o_sda(sda_o), .o_sda_oe(sda_oe), .i_pass_all(pass_all), .i_remote_ack(r_ack),
        .o_fwd_start(fwd_start), .o_fwd_valid(fwd_valid), .o_fwd_addr(fwd_addr), .o_fwd_data(fwd_data),
        .o_parity_chk_en(cfg[7]), .o_bc_crc_en(cfg[6]), .o_io_auto_detect(cfg[5]), .o_io_mode_high(cfg[4]),
        .o_pass_through_en(cfg[3]), .o_auto_ack_en(cfg[2]), .o_parity_rst(cfg[1]),
        .o_strobe_rising(cfg[0]), .o_eq_level(eq));
    lnkcfg_remote_model u_lnkcfg_remote_model (.i_sys_clk(sys_clk), .i_ack_en(ack_en),
        .i_fwd_start(fwd_start), .i_fwd_valid(fwd_valid), .i_fwd_addr(fwd_addr), .i_fwd_data(fwd_data),
        .o_remote_ack(r_ack), .o_last_addr(last_addr), .o_last_data(last_data), .o_byte_cnt(byte_cnt));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ****
    // i2c master, a quarter bit is four clocks so the two-flop sampler keeps up
    // ****
    task automatic q;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic start_c;
        m_sda = 1'b1;
        q;
        scl = 1'b1;
        q;
        m_sda = 1'b0;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic stop_c;
        m_sda = 1'b0;
        q;
        scl = 1'b1;
        q;
        m_sda = 1'b1;
        q;
    endtask
    // bit 0 is the ack slot: a 0 seen there means acked
    task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            m_sda = d[i];
            q;
            scl = 1'b1;
            q;
            r[i] = sda_w;
            q;
            scl = 1'b0;
            q;
        end
    endtask
    task automatic wr3(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1, output logic [2:0] ak);
        logic [8:0] r;
        start_c;
        xbyte({a, 2'b01}, r);
        ak[2] = ~r[0];
        xbyte({b0, 1'b1}, r);
        ak[1] = ~r[0];
        xbyte({b1, 1'b1}, r);
        ak[0] = ~r[0];
        stop_c;
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        logic [2:0] ak;
        wr3(LNKCFG_DEV_ADDR_DFLT, ra, d, ak);
    endtask
    task automatic rd(input logic [7:0] ra, output logic [7:0] d);
        logic [8:0] r;
        start_c;
        xbyte({LNKCFG_DEV_ADDR_DFLT, 2'b01}, r);
        xbyte({ra, 1'b1}, r);
        start_c;
        xbyte({LNKCFG_DEV_ADDR_DFLT, 2'b11}, r);
        xbyte(9'h1FF, r);
        d = r[8:1];
        stop_c;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        logic [7:0] d;
        chk("cfg1 outputs", cfg, 8'hE9);
        chk("eq level", {eq, 4'h0}, 8'h00);
        rd(LNKCFG_GEN_CFG1_OFS, d);
        chk("cfg1 read", d, 8'hE9);
        rd(LNKCFG_EQ_CTRL_OFS, d);
        chk("eq read", d, 8'h00);
    endtask
    task automatic t_cfg;
        logic [7:0] v[5] = '{8'hA9, 8'hC9, 8'hE5, 8'hF8, 8'h00};
        logic [7:0] d;
        foreach (v[i]) begin
            wr(LNKCFG_GEN_CFG1_OFS, v[i]);
            q;
            chk("cfg1 outputs", cfg, v[i]);
            rd(LNKCFG_GEN_CFG1_OFS, d);
            chk("cfg1 read", d, v[i]);
        end
    endtask
    task automatic t_parity;
        logic [7:0] d;
        wr(LNKCFG_GEN_CFG1_OFS, 8'hEB);
        rd(LNKCFG_GEN_CFG1_OFS, d);
        chk("parity reset held", d, 8'hEB);
        chk("parity reset out", {7'h00, cfg[1]}, 8'h01);
        wr(LNKCFG_GEN_CFG1_OFS, 8'hE9);
        q;
        chk("parity reset out", {7'h00, cfg[1]}, 8'h00);
    endtask
    task automatic t_eq;
        logic [3:0] c[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
        logic [7:0] d;
        foreach (c[i]) begin
            wr(LNKCFG_EQ_CTRL_OFS, {c[i], ~c[i]});
            q;
            chk("eq level", {4'h0, eq}, {4'h0, c[i]});
            rd(LNKCFG_EQ_CTRL_OFS, d);
            chk("eq read", d, {c[i], ~c[i]});
        end
    endtask
    task automatic t_fwd;
        logic [2:0] ak;
        wr(LNKCFG_REMOTE_SERIALIZER_ADDRESS_OFS, 8'h24);
        wr(LNKCFG_SERIALIZER_ALIAS_ADDRESS_OFS, 8'h50);
        wr(LNKCFG_GEN_CFG1_OFS, 8'hED);
        wr3(7'h28, 8'h5A, 8'hC3, ak);
        chk("auto ack", {5'h00, ak}, 8'h07);
        chk("fwd address", {1'b0, last_addr}, 8'h12);
        chk("fwd data", last_data, 8'hC3);
        chk("fwd bytes", byte_cnt, 8'h02);
        wr(LNKCFG_GEN_CFG1_OFS, 8'hE9);
        wr3(7'h28, 8'h11, 8'h22, ak);
        chk("remote nack", {7'h00, ak[0]}, 8'h00);
        ack_en = 1'b1;
        wr3(7'h28, 8'h33, 8'h44, ak);
        chk("remote ack", {5'h00, ak}, 8'h07);
        chk("fwd data", last_data, 8'h44);
        wr(LNKCFG_GEN_CFG1_OFS, 8'hE1);
        wr3(7'h28, 8'h55, 8'h66, ak);
        chk("pass off", {5'h00, ak}, 8'h00);
        pass_all = 1'b1;
        wr(LNKCFG_GEN_CFG1_OFS, 8'hED);
        wr3(7'h55, 8'h77, 8'h88, ak);
        chk("pass all ack", {5'h00, ak}, 8'h07);
        chk("pass all data", last_data, 8'h88);
    endtask
    task automatic summarize;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            summarize;
        end
    end
    initial begin
        {rst_n, scl, m_sda, pass_all, ack_en} = 5'b01100;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset;
        t_cfg;
        t_parity;
        t_eq;
        t_fwd;
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset;
        summarize;
    end
endmodule // tb_top
